// *** verilog/decimator_sequence_control.sv ***
// Purpose: filter-side sequencing: modulator clock, alignment, decimation, reset and power-down
// Assumes: pins are asynchronous; registers reached over AXI4-Lite
// Notes: pin inputs pass two flops, adding two cycles to every pin reaction
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module decimator_sequence_control
	import decim_ctrl_pkg::*;
(
	// System
	input wire logic clock,
	input wire logic resetn,
	// Host control pins
	input wire logic reset_pin,
	input wire logic power_down_request,
	input wire logic alignment_strobe,
	input wire logic decim_rate_bit2,
	input wire logic decim_rate_bit1,
	input wire logic decim_rate_bit0,
	input wire logic offset_calibrate_request,
	input wire logic apply_offset_correction,
	input wire logic channel_select,
	input wire logic half_rate_select,
	// Modulator link
	input wire logic modulator_bitstream,
	input wire logic modulator_bitstream_n,
	input wire logic modulator_overrange_flag,
	output logic modulator_clock,
	output logic modulator_align_pulse,
	// Conversion output
	output logic data_ready_flag,
	output logic [23:0] data_word,
	// AXI4-Lite write
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	function automatic logic [12:0] decim_period(input logic [2:0] code);
		logic [2:0] c;
		c = (code > DECIM_CODE_MAX) ? DECIM_CODE_MAX : code;
		decim_period = 13'(32'd1 << (DECIM_LOG_BASE + int'(c)));
	endfunction

	function automatic logic [23:0] scale_code(input logic signed [13:0] sum, input logic [2:0] code);
		logic [2:0] c;
		logic signed [31:0] wide;
		c = (code > DECIM_CODE_MAX) ? DECIM_CODE_MAX : code;
		wide = (32'(sum) * SCALE_FACTOR) <<< (5'd12 - 5'(c));
		if (wide > 32'(signed'({8'h00, CODE_POS_OVER})))
			scale_code = CODE_POS_OVER;
		else if (wide < 32'(signed'(CODE_NEG_OVER)))
			scale_code = CODE_NEG_OVER;
		else
			scale_code = wide[23:0];
	endfunction

	logic [PIN_COUNT-1:0] pins_sync;
	logic reset_s, pd_s, strobe_s, cal_s, use_off_s, chan_s, hbr_s, bit_s, bit_n_s, mflag_s;
	logic [2:0] decim_s;
	logic strobe_prev, por_active, in_reset, pd_effective;
	logic [1:0] por_fill;
	logic sync_event, soft_strobe, tick, mclk_rise, window_end, in_step;
	seq_state_type state;
	logic [7:0] config_reg;
	logic [23:0] offset_reg;
	logic [6:0] status_flags;
	logic [$clog2(MCLK_HALF_CYCLES+1)-1:0] mclk_count;
	logic [$clog2(ALIGN_PULSE_CYCLES+1)-1:0] align_count;
	logic [12:0] tick_count;
	logic signed [13:0] sum, next_sum;
	logic [23:0] next_code;
	logic aw_held, w_held, do_write, rd_take;
	logic [7:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;

	pin_synchronizer #(.WIDTH(PIN_COUNT)) pin_sync_inst (
		.clock(clock),
		.resetn(resetn),
		.pin_async({reset_pin, power_down_request, alignment_strobe, decim_rate_bit2, decim_rate_bit1,
			decim_rate_bit0, offset_calibrate_request, apply_offset_correction, channel_select,
			half_rate_select, modulator_bitstream, modulator_bitstream_n, modulator_overrange_flag}),
		.pin_sync(pins_sync)
	);
	assign {reset_s, pd_s, strobe_s, decim_s, cal_s, use_off_s, chan_s, hbr_s, bit_s, bit_n_s, mflag_s} = pins_sync;

	oversample_divider divider_inst (
		.clock(clock),
		.resetn(resetn),
		.mclk_rise(mclk_rise),
		.align(modulator_align_pulse),
		.half_rate_select(hbr_s),
		.tick(tick)
	);

	// Sync stages hold zeros for two edges after power-on
	// Leaving reset before they fill would load config from zeros, not from the pins
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			por_fill <= 2'h0;
		else
			por_fill <= {por_fill[0], 1'b1};
	end

	// Power-on reset: a constant at async reset, released by the first edge after the sync stages fill with the synced pin low
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			por_active <= 1'b1;
		else if (por_fill[1] && !reset_s)
			por_active <= 1'b0;
	end
	assign in_reset = por_active | reset_s;
	assign pd_effective = pd_s | config_reg[CFG_POWER_DOWN];

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			strobe_prev <= 1'b0;
		else
			strobe_prev <= strobe_s;
	end
	// A held strobe gives one event only
	assign sync_event = (strobe_s & ~strobe_prev) | soft_strobe;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			state <= st_reset;
		else if (in_reset)
			state <= st_reset;
		else begin
			unique case (state)
				st_reset: begin
					state <= st_idle;
				end
				st_idle: begin
					if (pd_effective)
						state <= st_power_down;
					else if (sync_event)
						state <= st_run;
				end
				st_run: begin
					if (pd_effective)
						state <= st_power_down;
				end
				st_power_down: begin
					if (!pd_effective)
						state <= st_idle;
				end
			endcase
		end
	end

	// Master clock to the modulator; stops low outside running states
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			mclk_count <= '0;
			modulator_clock <= 1'b0;
		end else if (state == st_reset || state == st_power_down) begin
			mclk_count <= '0;
			modulator_clock <= 1'b0;
		end else if (mclk_count == $bits(mclk_count)'(MCLK_HALF_CYCLES - 1)) begin
			mclk_count <= '0;
			modulator_clock <= ~modulator_clock;
		end else
			mclk_count <= mclk_count + 1'b1;
	end
	assign mclk_rise = (mclk_count == $bits(mclk_count)'(MCLK_HALF_CYCLES - 1)) && !modulator_clock &&
		(state == st_idle || state == st_run);

	// Event is in step when it lands on a decimation boundary of a running conversion
	assign in_step = (state == st_run) && (tick_count == 13'h0000) && !modulator_align_pulse;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			align_count <= '0;
			modulator_align_pulse <= 1'b0;
		end else if (state == st_reset || state == st_power_down || pd_effective) begin
			align_count <= '0;
			modulator_align_pulse <= 1'b0;
		end else if (sync_event && (state == st_idle || !in_step)) begin
			align_count <= $bits(align_count)'(ALIGN_PULSE_CYCLES - 1);
			modulator_align_pulse <= 1'b1;
		end else if (align_count != '0)
			align_count <= align_count - 1'b1;
		else
			modulator_align_pulse <= 1'b0;
	end

	// Accumulation of the bitstream over one decimation window
	assign window_end = tick && (tick_count == decim_period(config_reg[CFG_DECIM_MSB:0]) - 13'h0001);
	assign next_sum = sum + ((bit_s & ~bit_n_s) ? 14'sh0001 : -14'sh0001);
	assign next_code = scale_code(next_sum, config_reg[CFG_DECIM_MSB:0]);
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			tick_count <= 13'h0000;
			sum <= 14'sh0000;
		end else if (state != st_run || modulator_align_pulse || (sync_event && !in_step)) begin
			tick_count <= 13'h0000;
			sum <= 14'sh0000;
		end else if (window_end) begin
			tick_count <= 13'h0000;
			sum <= 14'sh0000;
		end else if (tick && !pd_effective) begin
			tick_count <= tick_count + 13'h0001;
			sum <= next_sum;
		end
	end

	// Output word, offset calibration and data ready
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			data_word <= CODE_ZERO;
			offset_reg <= CODE_ZERO;
			data_ready_flag <= 1'b0;
		end else if (state == st_reset) begin
			data_word <= CODE_ZERO;
			offset_reg <= CODE_ZERO;
			data_ready_flag <= 1'b0;
		end else if (state == st_idle && sync_event && !pd_effective) begin
			data_ready_flag <= 1'b1;
		end else if (state != st_run) begin
			data_ready_flag <= 1'b0;
		end else if (window_end) begin
			if (config_reg[CFG_CALIBRATE])
				offset_reg <= next_code;
			data_word <= (config_reg[CFG_USE_OFFSET] && !config_reg[CFG_CALIBRATE]) ?
				next_code - offset_reg : next_code;
			data_ready_flag <= 1'b1;
		end else if (rd_take && s_axi_araddr == DATA_OFFSET)
			data_ready_flag <= 1'b0;
	end

	// Configuration: loaded from pins in reset, then software-writable, kept in power-down
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			config_reg <= 8'h00;
		else if (state == st_reset)
			config_reg <= {pd_s, cal_s, use_off_s, chan_s, 1'b0, decim_s};
		else if (do_write && aw_addr == CONFIG_OFFSET && w_strb[0])
			config_reg <= {w_data[7:4], 1'b0, w_data[2:0]};
		else if (state == st_run && window_end && config_reg[CFG_CALIBRATE])
			config_reg[CFG_CALIBRATE] <= 1'b0;
	end
	assign soft_strobe = do_write && aw_addr == CONTROL_OFFSET && w_strb[0] && w_data[CTL_SOFT_STROBE];

	// Sticky flags: a set in the clearing cycle wins
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			status_flags <= 7'h00;
		else if (state == st_reset)
			status_flags <= 7'h00;
		else begin
			if (rd_take && s_axi_araddr == STATUS_OFFSET)
				status_flags <= 7'h00;
			if (state == st_run && window_end && (next_code == CODE_POS_OVER || next_code == CODE_NEG_OVER))
				status_flags[ST_OVERRANGE] <= 1'b1;
			if (state != st_power_down && mflag_s)
				status_flags[ST_MOD_FLAG] <= 1'b1;
			if (state == st_run && tick && (bit_s == bit_n_s))
				status_flags[ST_PAIR_FAULT] <= 1'b1;
			if (state == st_run && window_end && config_reg[CFG_CALIBRATE])
				status_flags[ST_CALIBRATED] <= 1'b1;
		end
	end

	// AXI4-Lite write channel: address and data taken in either order
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr == CONFIG_OFFSET || aw_addr == CONTROL_OFFSET) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// AXI4-Lite read channel; data reads clear data ready and status reads clear the sticky flags
	assign rd_take = s_axi_arvalid && s_axi_arready;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else if (rd_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			unique case (s_axi_araddr)
				CONFIG_OFFSET: s_axi_rdata <= {24'h000000, config_reg};
				STATUS_OFFSET: s_axi_rdata <= {25'h0000000, status_flags[6:3], state == st_power_down,
					state == st_run, data_ready_flag};
				DATA_OFFSET: s_axi_rdata <= {8'h00, data_word};
				OFFSET_REG_OFFSET: s_axi_rdata <= {8'h00, offset_reg};
				CONTROL_OFFSET: s_axi_rdata <= 32'h00000000;
				default: begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end
endmodule

// *** pkg/decim_ctrl_pkg.sv ***
// Purpose: shared constants of the decimator sequence control block
// Assumes: 100 MHz system clock, AXI4-Lite register access
// Notes: register map, field positions, reset values and cycle counts
// Summary of operation
// - Oversampling clock is master clock divided by four, or eight when half-rate low.
// - Modulator delivers a complementary bitstream pair, one bit per oversampling period.
// - An alignment pulse goes to the modulator before any conversion starts.
// - Alignment pulse resets the master-clock divider to a defined phase.
// - Output is 24-bit two's complement: +ref 4FFFFF, zero 000000, -ref B00000.
// - Five percent overrange converts up to 53FFFF and AC0000; beyond may flag error.
// - Reset pin is seen on the following clock edge and holds all logic initialised; here the pin passes two sync flops first.
// - Operation resumes after reset release, idle until an alignment strobe event.
// - Reset zeroes memory, data, offset, flags and loads configuration from pins.
// - Power-on enters reset regardless of pin; first edge with pin low leaves it; here only once the sync stages have filled.
// - Power-down entered on the first clock edge after the request goes high; here the request passes two sync flops first.
// - In power-down modulator clock and alignment are low; bitstream and flag ignored.
// - Modulator powers itself down when its master clock stops.
// - Register access keeps working in power-down; data, offset, config are kept.
// - Power-down left on the first edge after request low, then idle until strobe; here the request passes two sync flops first.
// - Only a rising strobe edge followed by a clock edge makes an event; here a soft strobe write to the control register also makes one.
// - Strobe event aligns output and starts convolutions; first one raises data ready.
// - After the first event data ready comes once per decimation period.
// - In-step strobe events do nothing; out-of-step ones realign and discard data.
package decim_ctrl_pkg;
	localparam int CLOCK_FREQ_HZ = 100000000;
	localparam int MCLK_FREQ_HZ = 1024000;
	localparam int MCLK_HALF_CYCLES = CLOCK_FREQ_HZ / (2 * MCLK_FREQ_HZ);
	localparam int ALIGN_PULSE_CYCLES = 2 * MCLK_HALF_CYCLES;
	localparam int PIN_COUNT = 13;
	// Register byte offsets
	localparam logic [7:0] CONFIG_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET = 8'h04;
	localparam logic [7:0] DATA_OFFSET = 8'h08;
	localparam logic [7:0] OFFSET_REG_OFFSET = 8'h0C;
	localparam logic [7:0] CONTROL_OFFSET = 8'h10;
	// Configuration fields
	localparam int CFG_POWER_DOWN = 7;
	localparam int CFG_CALIBRATE = 6;
	localparam int CFG_USE_OFFSET = 5;
	localparam int CFG_CHANNEL = 4;
	localparam int CFG_DECIM_MSB = 2;
	// Status fields
	localparam int ST_DATA_READY = 0;
	localparam int ST_RUNNING = 1;
	localparam int ST_POWERED_DOWN = 2;
	localparam int ST_OVERRANGE = 3;
	localparam int ST_MOD_FLAG = 4;
	localparam int ST_PAIR_FAULT = 5;
	localparam int ST_CALIBRATED = 6;
	localparam int CTL_SOFT_STROBE = 0;
	// Output coding
	localparam logic [23:0] CODE_ZERO = 24'h000000;
	localparam logic [23:0] CODE_POS_FULL = 24'h4FFFFF;
	localparam logic [23:0] CODE_NEG_FULL = 24'hB00000;
	localparam logic [23:0] CODE_POS_OVER = 24'h53FFFF;
	localparam logic [23:0] CODE_NEG_OVER = 24'hAC0000;
	localparam logic signed [31:0] SCALE_FACTOR = 32'sh00000015;
	localparam int DECIM_LOG_BASE = 6;
	localparam logic [2:0] DECIM_CODE_MAX = 3'h6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef enum logic [1:0] {st_reset, st_idle, st_run, st_power_down} seq_state_type;
endpackage

// *** verilog/pin_synchronizer.sv ***
// Purpose: two-flop synchroniser for asynchronous pin inputs
// Assumes: each bit is an independent level
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module pin_synchronizer #(
	parameter int WIDTH = 1
) (
	// System
	input wire logic clock,
	input wire logic resetn,
	// Pins
	input wire logic [WIDTH-1:0] pin_async,
	output logic [WIDTH-1:0] pin_sync
);
	logic [WIDTH-1:0] stage_one;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			stage_one <= '0;
			pin_sync <= '0;
		end else begin
			stage_one <= pin_async;
			pin_sync <= stage_one;
		end
	end
endmodule

// *** verilog/oversample_divider.sv ***
// Purpose: modulator oversampling clock divider with phase reset
// Assumes: master clock rises are given as one-cycle pulses
// Notes: tick marks the bitstream sampling point
`timescale 1ns/1ps
module oversample_divider (
	// System
	input wire logic clock,
	input wire logic resetn,
	// Master clock and control
	input wire logic mclk_rise,
	input wire logic align,
	input wire logic half_rate_select,
	// Sampling point
	output logic tick
);
	logic [2:0] phase;
	logic [2:0] last_phase;

	assign last_phase = half_rate_select ? 3'h3 : 3'h7;

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			phase <= 3'h0;
			tick <= 1'b0;
		end else if (align) begin
			phase <= 3'h0;
			tick <= 1'b0;
		end else if (mclk_rise) begin
			tick <= (phase == last_phase);
			phase <= (phase == last_phase) ? 3'h0 : phase + 3'h1;
		end else begin
			// No master clock edges means no ticks: the modulator sleeps
			tick <= 1'b0;
		end
	end
endmodule

// *** dv/decim_seq_properties.sv ***
// Purpose: pin-level assertions for the decimator sequence control block
// Assumes: host pins pass two sync flops, so reactions lag the pin by 2-3 cycles
// Notes: pulse widths are counted in helper logic, not by long repetitions
`timescale 1ns/1ps
module decim_seq_properties (
	// System
	input wire logic clock,
	input wire logic resetn,
	// Host pins
	input wire logic reset_pin,
	input wire logic power_down_request,
	input wire logic alignment_strobe,
	input wire logic s_axi_wvalid,
	// Outputs
	input wire logic modulator_clock,
	input wire logic modulator_align_pulse,
	input wire logic data_ready_flag,
	input wire logic [23:0] data_word
);
	logic [7:0] clk_high;
	logic [7:0] align_high;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			clk_high <= 8'h00;
		else
			clk_high <= modulator_clock ? clk_high + 8'h01 : 8'h00;
	end
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn)
			align_high <= 8'h00;
		else
			align_high <= modulator_align_pulse ? align_high + 8'h01 : 8'h00;
	end
	default clocking @(posedge clock);
	endclocking
	default disable iff (!resetn);
	// Six cycles covers the sync lag plus the output register
	sequence pd_held;
		power_down_request [*6];
	endsequence
	sequence reset_held;
		reset_pin [*6];
	endsequence
	// Soft strobes excluded so only the held pin is judged
	sequence strobe_held;
		(alignment_strobe && !s_axi_wvalid) [*8];
	endsequence
	mclk_half_a: assert property (disable iff (!resetn || reset_pin || power_down_request)
		$fell(modulator_clock) |-> clk_high == 8'h30) else $error("modulator clock high phase wrong");
	align_width_a: assert property (disable iff (!resetn || reset_pin || power_down_request)
		$fell(modulator_align_pulse) |-> align_high == 8'h60) else $error("align pulse width wrong");
	pd_clock_low_a: assert property (pd_held |-> !modulator_clock)
		else $error("modulator clock runs in power-down");
	pd_align_low_a: assert property (pd_held |-> !modulator_align_pulse)
		else $error("align pulse high in power-down");
	pd_retain_a: assert property (pd_held |-> $stable(data_word))
		else $error("data word changed in power-down");
	reset_clear_a: assert property (reset_held |-> data_word == 24'h000000 && !data_ready_flag)
		else $error("reset left data or ready set");
	reset_quiet_a: assert property (reset_held |-> !modulator_clock && !modulator_align_pulse)
		else $error("link active during reset");
	strobe_once_a: assert property (strobe_held |-> !$rose(modulator_align_pulse))
		else $error("held strobe made another event");
	pd_exit_idle_a: assert property (pd_held ##1 (!power_down_request && !alignment_strobe) |=>
		!data_ready_flag [*2]) else $error("ready raised on power-down exit");
	reset_idle_a: assert property (reset_held ##1 (!reset_pin && !alignment_strobe) |=>
		!data_ready_flag [*2]) else $error("ready raised on reset exit");
endmodule
bind decimator_sequence_control decim_seq_properties decim_seq_properties_inst (
	.clock(clock),
	.resetn(resetn),
	.reset_pin(reset_pin),
	.power_down_request(power_down_request),
	.alignment_strobe(alignment_strobe),
	.s_axi_wvalid(s_axi_wvalid),
	.modulator_clock(modulator_clock),
	.modulator_align_pulse(modulator_align_pulse),
	.data_ready_flag(data_ready_flag),
	.data_word(data_word)
);

// *** dv/modulator_model.sv ***
// Purpose: behavioural modulator on the far side of the link
// Assumes: bench picks an all-ones or all-zeros density
// Notes: sleeps once its master clock is still for 2 us
`timescale 1ns/1ps
module modulator_model (
	// Link from filter
	input wire logic modulator_clock,
	input wire logic modulator_align_pulse,
	input wire logic half_rate_select,
	// Bench control
	input wire logic density_high,
	// Link to filter
	output logic bitstream,
	output logic bitstream_n,
	output logic overrange_flag
);
	logic [2:0] div_count = 3'h0;
	logic level = 1'b0;
	logic asleep = 1'b0;
	realtime last_edge = 0.0;
	always @(posedge modulator_clock or posedge modulator_align_pulse) begin
		last_edge = $realtime;
		asleep = 1'b0;
		if (modulator_align_pulse)
			div_count = 3'h0;
		else if (div_count == (half_rate_select ? 3'h3 : 3'h7)) begin
			div_count = 3'h0;
			level = density_high;
		end else
			div_count = div_count + 3'h1;
	end
	// Asleep outputs churn so a stale bit never passes for data
	always #100 begin
		asleep = ($realtime - last_edge) > 2000.0;
		if (asleep)
			level = ~level;
	end
	assign bitstream = level;
	assign bitstream_n = asleep ? level : ~level;
	assign overrange_flag = asleep & level;
endmodule

// *** dv/decimator_sequence_control_tb_top.sv ***
// Purpose: self-checking bench for the decimator sequence control block
// Assumes: decimation code 0 and half rate high give the shortest window
// Notes: registers reached only over AXI4-Lite
`timescale 1ns/1ps
module decimator_sequence_control_tb_top;
	import decim_ctrl_pkg::*;
	localparam int WIN = 64 * 4 * 2 * MCLK_HALF_CYCLES;
	logic clock, resetn, reset_pin, power_down_request, alignment_strobe, density_high;
	logic [2:0] decim_code;
	logic offset_calibrate_request, apply_offset_correction, channel_select, half_rate_select;
	logic modulator_bitstream, modulator_bitstream_n, modulator_overrange_flag;
	logic modulator_clock, modulator_align_pulse, data_ready_flag;
	logic [23:0] data_word;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	int err_total, tests_run, n;
	decimator_sequence_control decimator_sequence_control_inst (.clock(clock), .resetn(resetn),
		.reset_pin(reset_pin), .power_down_request(power_down_request), .alignment_strobe(alignment_strobe),
		.decim_rate_bit2(decim_code[2]), .decim_rate_bit1(decim_code[1]), .decim_rate_bit0(decim_code[0]),
		.offset_calibrate_request(offset_calibrate_request), .apply_offset_correction(apply_offset_correction),
		.channel_select(channel_select), .half_rate_select(half_rate_select),
		.modulator_bitstream(modulator_bitstream), .modulator_bitstream_n(modulator_bitstream_n),
		.modulator_overrange_flag(modulator_overrange_flag), .modulator_clock(modulator_clock),
		.modulator_align_pulse(modulator_align_pulse), .data_ready_flag(data_ready_flag), .data_word(data_word),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
	modulator_model modulator_model_inst (.modulator_clock(modulator_clock),
		.modulator_align_pulse(modulator_align_pulse), .half_rate_select(half_rate_select),
		.density_high(density_high), .bitstream(modulator_bitstream), .bitstream_n(modulator_bitstream_n),
		.overrange_flag(modulator_overrange_flag));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// Run needs about 52k cycles
	initial begin
		repeat (95000) @(posedge clock);
		err_total++;
		tally_and_finish();
	end
	task automatic tally_and_finish();
		if (err_total == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_total++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Extra edge at the end keeps back-to-back calls from driving a signal twice in one step
	task automatic axi_write(input logic [7:0] addr, input logic [31:0] data);
		s_axi_awaddr <= addr;
		s_axi_wdata <= data;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awvalid && s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready));
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic axi_read(input logic [7:0] addr);
		s_axi_araddr <= addr;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arvalid && s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready));
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clock);
	endtask
	task automatic wait_dr(input int limit);
		n = 0;
		while (data_ready_flag !== 1'b1 && n < limit) begin
			@(posedge clock);
			n++;
		end
	endtask
	task automatic reset_state_test();
		axi_read(CONFIG_OFFSET);
		check(rd, 32'h00000030);
		axi_read(STATUS_OFFSET);
		check(rd, 32'h00000000);
		axi_read(OFFSET_REG_OFFSET);
		check(rd, 32'h00000000);
		axi_read(8'h14);
		check(32'(resp), 32'(RESP_SLVERR));
		axi_write(STATUS_OFFSET, 32'h000000FF);
		check(32'(resp), 32'(RESP_SLVERR));
		repeat (800) @(posedge clock);
		check(32'({data_ready_flag, data_word}), 32'h0);
	endtask
	task automatic first_event_test();
		alignment_strobe <= 1'b1;
		wait_dr(8);
		check(32'(n <= 5), 32'h1);
		check(32'(modulator_align_pulse), 32'h1);
		axi_read(DATA_OFFSET);
		check(rd, 32'h0);
		wait_dr(WIN + 400);
		check(32'(n > WIN - 400 && n < WIN + 400), 32'h1);
		axi_read(DATA_OFFSET);
		check(rd, {8'h00, CODE_POS_OVER});
		axi_read(STATUS_OFFSET);
		check(32'(rd[ST_OVERRANGE]), 32'h1);
		check(32'(rd[ST_RUNNING]), 32'h1);
	endtask
	task automatic realign_test();
		density_high <= 1'b0;
		alignment_strobe <= 1'b0;
		repeat (1000) @(posedge clock);
		axi_write(CONTROL_OFFSET, 32'h00000001);
		repeat (4) @(posedge clock);
		check(32'(modulator_align_pulse), 32'h1);
		wait_dr(WIN + 400);
		check(32'(n > WIN - 400 && n < WIN + 400), 32'h1);
		axi_read(DATA_OFFSET);
		check(rd, {8'h00, CODE_NEG_OVER});
	endtask
	task automatic power_down_test();
		channel_select <= 1'b0;
		power_down_request <= 1'b1;
		repeat (400) @(posedge clock);
		check(32'({modulator_clock, modulator_align_pulse}), 32'h0);
		axi_read(STATUS_OFFSET);
		check(32'(rd[ST_POWERED_DOWN]), 32'h1);
		check(32'(rd[5:4]), 32'h0);
		axi_read(DATA_OFFSET);
		check(rd, {8'h00, CODE_NEG_OVER});
		axi_read(CONFIG_OFFSET);
		check(rd, 32'h00000030);
		power_down_request <= 1'b0;
		n = 0;
		while (modulator_clock !== 1'b1 && n < 200) begin
			@(posedge clock);
			n++;
		end
		check(32'({modulator_clock, data_ready_flag}), 32'h2);
	endtask
	task automatic reset_pin_test();
		decim_code <= 3'h3;
		channel_select <= 1'b1;
		reset_pin <= 1'b1;
		repeat (6) @(posedge clock);
		check(32'({data_ready_flag, data_word}), 32'h0);
		reset_pin <= 1'b0;
		axi_read(CONFIG_OFFSET);
		check(rd, 32'h00000033);
		repeat (300) @(posedge clock);
		check(32'(data_ready_flag), 32'h0);
	endtask
	initial begin
		{resetn, reset_pin, power_down_request, alignment_strobe, offset_calibrate_request} = 5'h00;
		{apply_offset_correction, channel_select, half_rate_select, density_high} = 4'hF;
		decim_code = 3'h0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hF;
		err_total = 0;
		tests_run = 0;
		repeat (20) @(posedge clock);
		resetn <= 1'b1;
		// Config loads from synced pins a few edges after release
		repeat (8) @(posedge clock);
		reset_state_test();
		first_event_test();
		realign_test();
		power_down_test();
		reset_pin_test();
		tally_and_finish();
	end
endmodule
